// File: hdl/bpsr_ctrl.v
// Purpose: power-state tracking, event conversion and reset sequencing
// Assumes: clk 40 MHz; perst_n asynchronous to clk; aux-domain regs kept on sys_rst
// Notes: sys_rst models aux power-on reset only; perst_n resets main domain
`timescale 1ns/1ps
`include "bpsr_map.vh"

// Functional notes
// - function states D0, D3-hot, D3-cold only; D1/D2 requests are refused.
// - link tracks L0, L0s, L1, L2/L3 ready and L3.
// - parallel bus port tracks B0, B1, B2 and B3.
// - sticky state lives on aux reset, survives main reset in D3-hot.
// - forward mode: power-event pin assertion becomes upstream PM message.
// - reverse mode: received PM message drives pin low until serviced.
// - idle link drops to L0s then L1 autonomously when enabled.
// - beacon generated for wake; no wake sideband output exists.
// - serial functions held in reset while PERST# asserted.
// - PERST# accepted as asynchronous reset input.
// - link stays electrically idle for a minimum time after PERST# release.
module bpsr_ctrl (
    input wire clk,
    input wire sys_rst,
    input wire perst_n,
    input wire reverse_mode,
    input wire [1:0] dstate_req,
    input wire dstate_req_valid,
    input wire aux_pwr_lost,
    input wire [1:0] bus_state_req,
    input wire bus_state_req_valid,
    input wire link_idle,
    input wire link_l23_req,
    input wire link_wake_req,
    input wire aspm_en,
    input wire power_event_request_in_n,
    input wire pm_msg_rx,
    input wire pm_serviced,
    input wire sticky_wr,
    input wire [7:0] sticky_wdata,
    output reg func_rst_n,
    output reg elec_idle,
    output reg train_en,
    output reg [2:0] dstate,
    output reg dstate_refused,
    output reg [4:0] lstate,
    output reg [1:0] bstate,
    output reg pm_msg_tx,
    output reg power_event_request_out,
    output reg power_event_request_oe,
    output reg beacon,
    output reg [7:0] sticky_q,
    output reg pme_status
);

    // --------------------------------------------------------------
    // reset synchronizer
    // --------------------------------------------------------------
    reg rst_s1_q;
    reg rst_s2_q;
    // assert is immediate, release is clocked: no glitchy release
    always @(posedge clk or negedge perst_n) begin
        if (!perst_n) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire main_rst = sys_rst | ~rst_s2_q;

    always @(posedge clk or posedge main_rst) begin
        if (main_rst)
            func_rst_n <= 1'b0;
        else
            func_rst_n <= 1'b1;
    end

    // --------------------------------------------------------------
    // electrical idle hold after release
    // --------------------------------------------------------------
    localparam integer IDLE_EXIT_I = `BPSR_IDLE_EXIT_CYC;
    // count fits the counter width; the cut to that width is deliberate
    localparam [`BPSR_CNT_W-1:0] IDLE_EXIT = IDLE_EXIT_I[`BPSR_CNT_W-1:0];
    // training stays blocked while the count runs, even if the far end is ready
    reg [`BPSR_CNT_W-1:0] idle_cnt_q;
    always @(posedge clk or posedge main_rst) begin
        if (main_rst) begin
            idle_cnt_q <= {`BPSR_CNT_W{1'b0}};
            elec_idle <= 1'b1;
            train_en <= 1'b0;
        end else if (idle_cnt_q != IDLE_EXIT) begin
            idle_cnt_q <= idle_cnt_q + 1'b1;
        end else begin
            elec_idle <= 1'b0;
            train_en <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // device state
    // --------------------------------------------------------------
    function is_supported;
        input [1:0] req;
        begin
            is_supported = (req == `BPSR_DREQ_D0) || (req == `BPSR_DREQ_D3);
        end
    endfunction

    // aux domain: D3-cold is tracked across main loss
    // D3-cold is left only once the main domain is out of reset again,
    // so a request strobe can never race the return to D0
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dstate <= `BPSR_D0;
            dstate_refused <= 1'b0;
        end else begin
            dstate_refused <= 1'b0;
            if (aux_pwr_lost)
                dstate <= `BPSR_D3COLD;
            else if (!rst_s2_q && dstate == `BPSR_D3COLD)
                dstate <= `BPSR_D3COLD;
            else if (dstate == `BPSR_D3COLD && rst_s2_q)
                dstate <= `BPSR_D0;
            else if (dstate_req_valid) begin
                if (!is_supported(dstate_req))
                    dstate_refused <= 1'b1;
                else if (dstate_req == `BPSR_DREQ_D3)
                    dstate <= `BPSR_D3HOT;
                else
                    dstate <= `BPSR_D0;
            end
        end
    end

    // --------------------------------------------------------------
    // sticky registers on aux reset
    // --------------------------------------------------------------
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            sticky_q <= 8'h00;
        else if (sticky_wr && func_rst_n)
            sticky_q <= sticky_wdata;
    end

    // --------------------------------------------------------------
    // bus power state
    // --------------------------------------------------------------
    always @(posedge clk or posedge main_rst) begin
        if (main_rst)
            bstate <= `BPSR_B0;
        else if (dstate == `BPSR_D3HOT)
            bstate <= `BPSR_B3;
        else if (bus_state_req_valid)
            bstate <= bus_state_req;
    end

    // --------------------------------------------------------------
    // link state with ASPM
    // --------------------------------------------------------------
    localparam integer L0S_IDLE_I = `BPSR_L0S_IDLE_CYC;
    localparam integer L1_IDLE_I = `BPSR_L1_IDLE_CYC;
    // both counts fit the counter width; cut on purpose
    localparam [`BPSR_CNT_W-1:0] L0S_IDLE = L0S_IDLE_I[`BPSR_CNT_W-1:0];
    localparam [`BPSR_CNT_W-1:0] L1_IDLE = L1_IDLE_I[`BPSR_CNT_W-1:0];
    // one shared counter: L1 timing restarts on entry to L0s, so the
    // total idle time before L1 is the sum of both counts
    reg [`BPSR_CNT_W-1:0] aspm_cnt_q;
    reg [4:0] lstate_d;
    always @* begin
        lstate_d = lstate;
        case (lstate)
            `BPSR_L0: begin
                if (link_l23_req)
                    lstate_d = `BPSR_L23R;
                else if (aspm_en && link_idle && aspm_cnt_q >= L0S_IDLE)
                    lstate_d = `BPSR_L0S;
            end
            `BPSR_L0S: begin
                if (!link_idle || link_wake_req)
                    lstate_d = `BPSR_L0;
                else if (aspm_cnt_q >= L1_IDLE)
                    lstate_d = `BPSR_L1;
            end
            `BPSR_L1: begin
                if (!link_idle || link_wake_req)
                    lstate_d = `BPSR_L0;
            end
            `BPSR_L23R: begin
                if (link_wake_req)
                    lstate_d = `BPSR_L0;
                else if (dstate == `BPSR_D3COLD)
                    lstate_d = `BPSR_L3;
            end
            `BPSR_L3: begin
                if (dstate != `BPSR_D3COLD)
                    lstate_d = `BPSR_L0;
            end
            default: lstate_d = `BPSR_L0;
        endcase
    end

    always @(posedge clk or posedge main_rst) begin
        if (main_rst) begin
            lstate <= `BPSR_L0;
            aspm_cnt_q <= {`BPSR_CNT_W{1'b0}};
        end else begin
            lstate <= lstate_d;
            // counter restarts on every state change or traffic
            if (lstate_d != lstate || !link_idle || !aspm_en)
                aspm_cnt_q <= {`BPSR_CNT_W{1'b0}};
            else if (aspm_cnt_q != {`BPSR_CNT_W{1'b1}})
                aspm_cnt_q <= aspm_cnt_q + 1'b1;
        end
    end

    // --------------------------------------------------------------
    // power-event conversion
    // --------------------------------------------------------------
    reg pe_s1_q;
    reg pe_s2_q;
    reg pe_prev_q;
    always @(posedge clk or posedge main_rst) begin
        if (main_rst) begin
            pe_s1_q <= 1'b1;
            pe_s2_q <= 1'b1;
            pe_prev_q <= 1'b1;
        end else begin
            pe_s1_q <= power_event_request_in_n;
            pe_s2_q <= pe_s1_q;
            pe_prev_q <= pe_s2_q;
        end
    end
    // reset value matches the idle-high pin, so no false edge after reset
    wire pe_fall = pe_prev_q & ~pe_s2_q;

    always @(posedge clk or posedge main_rst) begin
        if (main_rst) begin
            pm_msg_tx <= 1'b0;
            power_event_request_out <= 1'b0;
            power_event_request_oe <= 1'b0;
        end else begin
            pm_msg_tx <= ~reverse_mode & pe_fall;
            // open drain: data stays low, only the enable moves
            power_event_request_out <= 1'b0;
            // a new message in the same cycle as service keeps the pin pulled
            if (!reverse_mode)
                power_event_request_oe <= 1'b0;
            else if (pm_msg_rx)
                power_event_request_oe <= 1'b1;
            else if (pm_serviced)
                power_event_request_oe <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // beacon
    // --------------------------------------------------------------
    function link_is_low;
        input [4:0] st;
        begin
            link_is_low = (st == `BPSR_L23R) || (st == `BPSR_L1);
        end
    endfunction

    // low-power link: wake by beacon rather than a sideband pin;
    // L0s needs none since it exits on traffic by itself
    always @(posedge clk or posedge main_rst) begin
        if (main_rst)
            beacon <= 1'b0;
        else
            beacon <= ~reverse_mode & ~pe_s2_q & link_is_low(lstate);
    end

    // --------------------------------------------------------------
    // event status
    // --------------------------------------------------------------
    // sticky event status, set wins over clear
    // kept on aux reset so software still sees the event after main loss
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            pme_status <= 1'b0;
        else if ((reverse_mode & pm_msg_rx) | (~reverse_mode & pe_fall))
            pme_status <= 1'b1;
        else if (pm_serviced)
            pme_status <= 1'b0;
    end

endmodule

// File: hdl/bpsr_map.vh
// Purpose: constants for the bridge power-state and reset controller
// Assumes: 40 MHz core clock
// Notes: device and link states are one-hot codes; bus states and D requests are binary
`ifndef BPSR_MAP_VH
`define BPSR_MAP_VH
`define BPSR_CLK_MHZ 40
// function device states
`define BPSR_D0 3'h1
`define BPSR_D3HOT 3'h2
`define BPSR_D3COLD 3'h4
`define BPSR_DREQ_D0 2'h0
`define BPSR_DREQ_D1 2'h1
`define BPSR_DREQ_D2 2'h2
`define BPSR_DREQ_D3 2'h3
// link states
`define BPSR_L0 5'h01
`define BPSR_L0S 5'h02
`define BPSR_L1 5'h04
`define BPSR_L23R 5'h08
`define BPSR_L3 5'h10
// parallel bus states
`define BPSR_B0 2'h0
`define BPSR_B1 2'h1
`define BPSR_B2 2'h2
`define BPSR_B3 2'h3
// timing
`define BPSR_IDLE_EXIT_US 20
`define BPSR_IDLE_EXIT_CYC (`BPSR_IDLE_EXIT_US * `BPSR_CLK_MHZ)
`define BPSR_L0S_IDLE_NS 1000
`define BPSR_L0S_IDLE_CYC ((`BPSR_L0S_IDLE_NS * `BPSR_CLK_MHZ) / 1000)
`define BPSR_L1_IDLE_US 20
`define BPSR_L1_IDLE_CYC (`BPSR_L1_IDLE_US * `BPSR_CLK_MHZ)
`define BPSR_CNT_W 16
`endif

// File: tb/bpsr_props.sv
// Purpose: checks on reset release, D-state requests and power events
// Assumes: bound to bpsr_ctrl
// Notes: the oe hold check stands down while perst_n is low
`timescale 1ns/1ps
module bpsr_props (
    input wire clk,
    input wire sys_rst,
    input wire perst_n,
    input wire reverse_mode,
    input wire [1:0] dstate_req,
    input wire dstate_req_valid,
    input wire power_event_request_in_n,
    input wire pm_msg_rx,
    input wire pm_serviced,
    input wire func_rst_n,
    input wire elec_idle,
    input wire train_en,
    input wire [2:0] dstate,
    input wire dstate_refused,
    input wire pm_msg_tx,
    input wire power_event_request_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire d_go = dstate_req_valid && func_rst_n;
    rst_hold_a: assert property (!perst_n |-> !func_rst_n && elec_idle && !train_en)
        else $error("reset not held");
    rst_sync_a: assert property (
        $rose(perst_n) |-> !func_rst_n ##1 !func_rst_n ##[1:2] func_rst_n)
        else $error("reset release early or late");
    idle_hold_a: assert property (
        $rose(func_rst_n) |-> (elec_idle && !train_en) [*8]) else $error("idle left early");
    d_refuse_a: assert property (
        d_go && dstate_req[0] != dstate_req[1] |=> dstate_refused && $stable(dstate))
        else $error("D1 or D2 taken");
    d_accept_a: assert property (d_go && dstate_req == 2'h3 |=> dstate == 3'h2)
        else $error("D3 not taken");
    fwd_msg_a: assert property (
        !reverse_mode && func_rst_n && $fell(power_event_request_in_n) |-> ##[3:4] pm_msg_tx)
        else $error("no upstream message");
    rev_pin_a: assert property (
        reverse_mode && func_rst_n && pm_msg_rx |=> power_event_request_oe)
        else $error("pin not pulled");
    oe_hold_a: assert property (disable iff (sys_rst || !perst_n)
        power_event_request_oe && !pm_serviced |=> power_event_request_oe)
        else $error("pin released early");
endmodule
bind bpsr_ctrl bpsr_props bpsr_props_i (.clk(clk), .sys_rst(sys_rst), .perst_n(perst_n),
    .reverse_mode(reverse_mode), .dstate_req(dstate_req), .dstate_req_valid(dstate_req_valid),
    .power_event_request_in_n(power_event_request_in_n), .pm_msg_rx(pm_msg_rx),
    .pm_serviced(pm_serviced), .func_rst_n(func_rst_n), .elec_idle(elec_idle),
    .train_en(train_en), .dstate(dstate), .dstate_refused(dstate_refused),
    .pm_msg_tx(pm_msg_tx), .power_event_request_oe(power_event_request_oe));

// File: tb/bpsr_plat.sv
// Purpose: platform reset controller and root complex stand-in
// Assumes: supplies and reference clock good when power_up starts
// Notes: hold_cyc stands in for the long supply hold
`timescale 1ns/1ps
module bpsr_plat #(
    parameter HOLD_CYC = 100
) (
    input wire clk,
    output reg perst_n = 1'h0,
    output reg pm_msg_rx = 1'h0,
    output reg pm_serviced = 1'h0
);
    // release lands off the edge: reset has no phase tie to the clock
    task power_up;
        begin
            repeat (HOLD_CYC) @(negedge clk);
            #3 perst_n = 1'h1;
        end
    endtask
    task power_fail;
        #7 perst_n = 1'h0; // reset first, clock keeps running
    endtask
    task strobe(input sel);
        begin
            @(negedge clk);
            pm_msg_rx = !sel;
            pm_serviced = sel;
            @(negedge clk);
            pm_msg_rx = 1'h0;
            pm_serviced = 1'h0;
        end
    endtask
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for bpsr_ctrl
// Assumes: 40 MHz clk, inputs change on falling edges
// Notes: aux-loss input held low
`timescale 1ns/1ps
`include "bpsr_map.vh"
module testbench;
    reg clk = 1'h0;
    reg sys_rst = 1'h1;
    reg rev = 1'h0, dv = 1'h0, bv = 1'h0, idle = 1'h0, aspm = 1'h0, pin_n = 1'h1, sw = 1'h0;
    reg [1:0] dq = 2'h0, bq = 2'h0;
    reg wk = 1'h0, l23 = 1'h0;
    reg [7:0] sd = 8'ha5;
    wire perst_n, rx, svc, frst_n, eidle, train, dref, tx, pout, oe, bcn, pme;
    wire [2:0] ds;
    wire [4:0] ls;
    wire [1:0] bs;
    wire [7:0] stq;
    integer fails = 0, check_count = 0, cyc = 0, i, n;
    initial forever #12.5 clk = ~clk;
    bpsr_plat #(.HOLD_CYC(100)) bpsr_plat_i (.clk(clk), .perst_n(perst_n), .pm_msg_rx(rx),
        .pm_serviced(svc));
    bpsr_ctrl bpsr_ctrl_i (.clk(clk), .sys_rst(sys_rst), .perst_n(perst_n), .reverse_mode(rev),
        .dstate_req(dq), .dstate_req_valid(dv), .aux_pwr_lost(1'h0), .bus_state_req(bq),
        .bus_state_req_valid(bv), .link_idle(idle), .link_l23_req(l23), .link_wake_req(wk),
        .aspm_en(aspm), .power_event_request_in_n(pin_n), .pm_msg_rx(rx), .pm_serviced(svc),
        .sticky_wr(sw), .sticky_wdata(sd), .func_rst_n(frst_n), .elec_idle(eidle),
        .train_en(train), .dstate(ds), .dstate_refused(dref), .lstate(ls), .bstate(bs),
        .pm_msg_tx(tx), .power_event_request_out(pout), .power_event_request_oe(oe),
        .beacon(bcn), .sticky_q(stq), .pme_status(pme));
    task chk(input [47:0] nm, input [7:0] exp, input [7:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("FAIL %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task end_sim(input integer extra);
        begin
            fails = fails + extra;
            $display("checks %0d fails %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task wn(input integer k);
        repeat (k) @(negedge clk);
    endtask
    task t_boot;
        begin
            chk("frst", 8'h00, frst_n);
            bpsr_plat_i.power_up;
            wn(5);
            chk("frst", 8'h01, frst_n);
            chk("train", 8'h00, train);
            wn(`BPSR_IDLE_EXIT_CYC);
            chk("train", 8'h01, train);
            chk("eidle", 8'h00, eidle);
        end
    endtask
    // D requests run 1,2,3,0 so both refusals come before the D3 entry
    task t_states;
        for (i = 0; i < 4; i = i + 1) begin
            bq = i[1:0];
            dq = bq + 2'h1;
            bv = 1'h1;
            wn(1);
            bv = 1'h0;
            chk("bstate", bq, bs);
            dv = 1'h1;
            wn(1);
            dv = 1'h0;
            chk("refuse", dq[0] ^ dq[1], dref);
            chk("dstate", dq == 2'h3 ? `BPSR_D3HOT : `BPSR_D0, ds);
        end
    endtask
    task t_sticky;
        begin
            chk("sticky", 8'h00, stq);
            sw = 1'h1;
            wn(1);
            sw = 1'h0;
            bpsr_plat_i.power_fail;
            wn(2);
            chk("sticky", 8'ha5, stq);
            t_boot;
            chk("sticky", 8'ha5, stq);
        end
    endtask
    task t_fwd;
        begin
            pin_n = 1'h0;
            n = 0;
            while (tx !== 1'h1 && n < 9) begin
                wn(1);
                n = n + 1;
            end
            chk("txdly", 8'h03, n[7:0]);
            chk("pme", 8'h01, pme);
            aspm = 1'h1;
            idle = 1'h1;
            wn(`BPSR_L0S_IDLE_CYC + 3);
            chk("lstate", `BPSR_L0S, ls);
            wn(`BPSR_L1_IDLE_CYC + 3);
            chk("lstate", `BPSR_L1, ls);
            chk("beacon", 8'h01, bcn);
            pin_n = 1'h1;
            wn(4);
            chk("beacon", 8'h00, bcn);
            wk = 1'h1;
            wn(2);
            chk("lstate", `BPSR_L0, ls);
            wk = 1'h0;
            l23 = 1'h1;
            wn(2);
            chk("lstate", `BPSR_L23R, ls);
            pin_n = 1'h0;
            wn(4);
            chk("beacon", 8'h01, bcn);
            pin_n = 1'h1;
            l23 = 1'h0;
            aspm = 1'h0;
            wk = 1'h1;
            wn(4);
            chk("beacon", 8'h00, bcn);
            chk("lstate", `BPSR_L0, ls);
            wk = 1'h0;
        end
    endtask
    task t_rev;
        begin
            rev = 1'h1;
            bpsr_plat_i.strobe(1'h1);
            chk("pme", 8'h00, pme);
            bpsr_plat_i.strobe(1'h0);
            chk("oe", 8'h01, oe);
            chk("pme", 8'h01, pme);
            chk("pout", 8'h00, pout);
            wn(4);
            chk("oe", 8'h01, oe);
            bpsr_plat_i.strobe(1'h1);
            chk("oe", 8'h00, oe);
            chk("pme", 8'h00, pme);
        end
    endtask
    initial begin
        wn(4);
        sys_rst = 1'h0;
        t_boot;
        t_states;
        t_sticky;
        t_fwd;
        t_rev;
        end_sim(0);
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 6000)
            end_sim(1);
    end
endmodule
